// ### design/wbl_pkg.sv
// Shared constants for the write-burst link: mode word layout, burst codes,
// spacing figures and the controller's register map.
// Assumes both ends import it and agree on the link widths given as parameters.
package wbl_pkg;
	// Pipeline depth; must exceed the largest write latency (31 + 31)
	localparam int WLMAX = 64;
	// Write-data slots held by the controller while bursts are in flight
	localparam int SLOTS = 16;
	// Link clock half period, in system clocks
	localparam int LINK_HALF = 2;
	// Burst mode codes in the low two bits of mode register zero
	localparam logic [1:0] BM_BL8 = 2'h0;
	localparam logic [1:0] BM_SEL = 2'h1;
	localparam logic [1:0] BM_BC4 = 2'h2;
	// Mode word field positions
	localparam int MF_BM = 0;
	localparam int MF_MASK = 2;
	localparam int MF_DBI = 3;
	localparam int MF_CRC = 4;
	localparam int MF_PRE2 = 5;
	localparam int MF_AL = 6;
	localparam int MF_CWL = 11;
	localparam int MF_LATW = 5;
	localparam logic [15:0] MODE_RST = 16'h0000;
	// Link cycles carrying data (two beats per cycle)
	localparam logic [2:0] CYC_BL8 = 3'h4;
	localparam logic [2:0] CYC_BC4 = 3'h2;
	// Precharge tail after write latency, in link clocks
	localparam logic [7:0] TAIL_BL8 = 8'h04;
	localparam logic [7:0] TAIL_BC4 = 8'h02;
	// Write-to-write spacing limits and the long-preamble column latency limit, in link clocks
	localparam logic [3:0] CCD_MIN = 4'h4;
	localparam logic [3:0] CCD_PRE2_BAD = 4'h5;
	localparam logic [3:0] SINCE_RST = 4'hF;
	localparam logic [4:0] CWL_PRE2_BAD = 5'h09;
	// Controller register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_MODE = 8'h04;
	localparam logic [7:0] REG_DATA0 = 8'h08;
	localparam logic [7:0] REG_DATA1 = 8'h0C;
	localparam logic [7:0] REG_DATA2 = 8'h10;
	localparam logic [7:0] REG_DATA3 = 8'h14;
	localparam logic [7:0] REG_MASK = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	// Command word fields
	localparam int CF_AP = 2;
	localparam int CF_BS = 3;
	localparam int CF_BANK = 4;
	localparam int CF_COL = 8;
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_ACT = 2'h1;
	localparam logic [1:0] OP_MODE = 2'h2;
endpackage

// ### design/wbl_link_if.sv
// Link between memory controller and DRAM write path.
// Assumes the controller end drives every signal, linkClk included.
`timescale 1ns/100ps
`default_nettype none
interface wbl_link_if #(
	parameter int DW = 8,
	parameter int NL = 1,
	parameter int BANKW = 4,
	parameter int COLW = 10
);
	logic linkClk;
	logic cmdWr;
	logic cmdAct;
	logic cmdMrs;
	logic apBit;
	logic bsBit;
	logic [BANKW-1:0] bank;
	logic [COLW-1:0] col;
	logic [15:0] mrsData;
	logic dqsEn;
	logic [2*DW-1:0] dq;
	logic [2*NL-1:0] maskInvN;
	modport dev (input linkClk, cmdWr, cmdAct, cmdMrs, apBit, bsBit, bank, col, mrsData,
		dqsEn, dq, maskInvN);
	modport ctl (output linkClk, cmdWr, cmdAct, cmdMrs, apBit, bsBit, bank, col, mrsData,
		dqsEn, dq, maskInvN);
endinterface
`default_nettype wire

// ### design/wbl_sdram_dev.sv
// DRAM write-burst path: command decode, latency pipeline, burst capture
// with lane masking, auto precharge and CRC mode reporting.
// Assumes the controller keeps write spacing and mode-set legality.
`timescale 1ns/100ps
`default_nettype none
module wbl_sdram_dev
	import wbl_pkg::*;
#(
	parameter int DW = 8,
	parameter int NL = 1,
	parameter int BANKW = 4,
	parameter int COLW = 10
)(
	wbl_link_if.dev link,
	input wire logic rst,
	output logic memWe,
	output logic [BANKW-1:0] memBank,
	output logic [COLW-1:0] memCol,
	output logic [2*DW-1:0] memData,
	output logic [2*NL-1:0] memLaneEn,
	output logic prechargeStart,
	output logic [BANKW-1:0] prechargeBank,
	output logic [(1<<BANKW)-1:0] bankOpen,
	output logic crcOn,
	output logic crcPersistent,
	output logic strobeErr
);
	localparam int LW = DW / NL;

	typedef struct packed {
		logic v;
		logic bc4;
		logic ap;
		logic [BANKW-1:0] bank;
		logic [COLW-1:0] col;
	} wbl_cmd_type;

	logic [15:0] mode_r, mode_nxt;
	wbl_cmd_type pipe_r [WLMAX];
	wbl_cmd_type pipe_nxt [WLMAX];
	wbl_cmd_type cur_r, cur_nxt;
	logic [2:0] left_r, left_nxt;
	logic [1:0] idx_r, idx_nxt;
	logic memWe_nxt;
	logic [BANKW-1:0] memBank_nxt;
	logic [COLW-1:0] memCol_nxt;
	logic [2*DW-1:0] memData_nxt;
	logic [2*NL-1:0] memLaneEn_nxt;
	logic prechargeStart_nxt;
	logic [BANKW-1:0] prechargeBank_nxt;
	logic [(1<<BANKW)-1:0] bankOpen_nxt;
	logic crcOn_nxt, crcPersistent_nxt, strobeErr_nxt;

	logic [1:0] burstMode;
	logic maskOn, invOn;
	logic [5:0] wl, tapIdx;
	wbl_cmd_type newCmd, tap, curE;
	logic start, active, last;
	logic [1:0] curIdx;
	logic [2:0] total;
	logic pinLow;
	logic [LW-1:0] lane;

	// Decoded mode fields
	always_comb begin
		burstMode = mode_r[MF_BM +: 2];
		maskOn = (DW != 4) && mode_r[MF_MASK] && !mode_r[MF_DBI];
		invOn = mode_r[MF_DBI];
		wl = {1'b0, mode_r[MF_AL +: MF_LATW]} + {1'b0, mode_r[MF_CWL +: MF_LATW]};
		tapIdx = wl - 6'h01;
	end

	// Command decode and latency pipeline
	always_comb begin
		mode_nxt = mode_r;
		if (link.cmdMrs) begin
			mode_nxt = link.mrsData;
		end
		newCmd.v = link.cmdWr;
		newCmd.ap = link.apBit;
		newCmd.bank = link.bank;
		newCmd.col = link.col;
		unique case (burstMode)
			BM_BC4: newCmd.bc4 = 1'b1;
			BM_SEL: newCmd.bc4 = !link.bsBit;
			default: newCmd.bc4 = 1'b0; // Reserved code runs as eight beats
		endcase
		pipe_nxt[0] = newCmd;
		for (int i = 1; i < WLMAX; i++) begin
			pipe_nxt[i] = pipe_r[i-1];
		end
	end

	// Burst sequencer; a new start overrides, which makes four-apart writes gapless
	always_comb begin
		tap = pipe_r[tapIdx];
		start = tap.v;
		curE = start ? tap : cur_r;
		curIdx = start ? 2'h0 : idx_r;
		total = curE.bc4 ? CYC_BC4 : CYC_BL8;
		active = start || (left_r != 3'h0);
		last = active && ({1'b0, curIdx} == total - 3'h1);
		cur_nxt = curE;
		idx_nxt = active ? curIdx + 2'h1 : 2'h0;
		if (start) begin
			left_nxt = total - 3'h1;
		end else if (left_r != 3'h0) begin
			left_nxt = left_r - 3'h1;
		end else begin
			left_nxt = 3'h0;
		end
	end

	// Lane masking or inversion on the shared pin
	always_comb begin
		memData_nxt = '0;
		memLaneEn_nxt = '0;
		pinLow = 1'b0;
		lane = '0;
		for (int b = 0; b < 2; b++) begin
			for (int l = 0; l < NL; l++) begin
				pinLow = !link.maskInvN[b*NL+l];
				lane = link.dq[b*DW+l*LW +: LW];
				if (invOn) begin
					// Inversion flag low means the lane arrived inverted
					memData_nxt[b*DW+l*LW +: LW] = pinLow ? ~lane : lane;
					memLaneEn_nxt[b*NL+l] = active;
				end else begin
					memData_nxt[b*DW+l*LW +: LW] = lane;
					// Without masking the pin is ignored (termination strobe role)
					memLaneEn_nxt[b*NL+l] = active && !(maskOn && pinLow);
				end
			end
		end
	end

	// Array write port, auto precharge and status
	always_comb begin
		memWe_nxt = active;
		memBank_nxt = curE.bank;
		memCol_nxt = curE.col + COLW'({curIdx, 1'b0});
		prechargeStart_nxt = last && curE.ap;
		prechargeBank_nxt = curE.bank;
		bankOpen_nxt = bankOpen;
		if (link.cmdAct) begin
			bankOpen_nxt[link.bank] = 1'b1;
		end
		// Plain writes leave the bank open; only the burst end of an autoprecharge closes
		if (last && curE.ap) begin
			bankOpen_nxt[curE.bank] = 1'b0;
		end
		crcOn_nxt = mode_r[MF_CRC];
		crcPersistent_nxt = mode_r[MF_CRC] && maskOn;
		strobeErr_nxt = active && !link.dqsEn;
	end

	// State registers on the link clock
	always_ff @(posedge link.linkClk or posedge rst) begin
		if (rst) begin
			mode_r <= MODE_RST;
			for (int i = 0; i < WLMAX; i++) begin
				pipe_r[i] <= '0;
			end
			cur_r <= '0;
			left_r <= 3'h0;
			idx_r <= 2'h0;
		end else begin
			mode_r <= mode_nxt;
			pipe_r <= pipe_nxt;
			cur_r <= cur_nxt;
			left_r <= left_nxt;
			idx_r <= idx_nxt;
		end
	end

	// Output registers
	always_ff @(posedge link.linkClk or posedge rst) begin
		if (rst) begin
			memWe <= 1'b0;
			memBank <= '0;
			memCol <= '0;
			memData <= '0;
			memLaneEn <= '0;
			prechargeStart <= 1'b0;
			prechargeBank <= '0;
			bankOpen <= '0;
			crcOn <= 1'b0;
			crcPersistent <= 1'b0;
			strobeErr <= 1'b0;
		end else begin
			memWe <= memWe_nxt;
			memBank <= memBank_nxt;
			memCol <= memCol_nxt;
			memData <= memData_nxt;
			memLaneEn <= memLaneEn_nxt;
			prechargeStart <= prechargeStart_nxt;
			prechargeBank <= prechargeBank_nxt;
			bankOpen <= bankOpen_nxt;
			crcOn <= crcOn_nxt;
			crcPersistent <= crcPersistent_nxt;
			strobeErr <= strobeErr_nxt;
		end
	end
endmodule
`default_nettype wire

// ### design/wbl_mem_ctl.sv
// Memory controller end: register port, link clock divider, write scheduling
// with latency, preamble, spacing and precharge-wait bookkeeping.
// Assumes software uses the plain strobe port on the same clock.
`timescale 1ns/100ps
`default_nettype none
module wbl_mem_ctl
	import wbl_pkg::*;
#(
	parameter int DW = 8,
	parameter int NL = 1,
	parameter int BANKW = 4,
	parameter int COLW = 10,
	parameter logic [7:0] TWR_CYC = 8'h0C
)(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [31:0] rdata,
	wbl_link_if.ctl link
);
	typedef struct packed {
		logic v;
		logic bc4;
		logic [3:0] slot;
	} wbl_sched_type;

	logic [31:0] rdata_nxt;
	logic [1:0] div_r, div_nxt;
	logic clk_r, clk_nxt, tick;
	logic [15:0] mode_r, mode_nxt, act_r, act_nxt;
	logic [31:0] data_r [4];
	logic [31:0] data_nxt [4];
	logic [15:0] mask_r, mask_nxt;
	logic pend_r, pend_nxt;
	logic [31:0] cmd_r, cmd_nxt;
	logic errCfg_r, errCfg_nxt, errBusy_r, errBusy_nxt;
	logic [3:0] since_r, since_nxt, slot_r, slot_nxt;
	logic [7:0] wait_r, wait_nxt;
	logic [8*DW-1:0] sData_r [SLOTS];
	logic [8*DW-1:0] sData_nxt [SLOTS];
	logic [8*NL-1:0] sMask_r [SLOTS];
	logic [8*NL-1:0] sMask_nxt [SLOTS];
	wbl_sched_type sch_r [WLMAX];
	wbl_sched_type sch_nxt [WLMAX];
	wbl_sched_type cur_r, cur_nxt, tap, curE;
	logic [2:0] left_r, left_nxt;
	logic [1:0] idx_r, idx_nxt, curIdx;
	logic oWr, oAct, oMrs, oAp, oBs, oDqs;
	logic oWr_nxt, oAct_nxt, oMrs_nxt, oAp_nxt, oBs_nxt, oDqs_nxt;
	logic [BANKW-1:0] oBank, oBank_nxt;
	logic [COLW-1:0] oCol, oCol_nxt;
	logic [15:0] oMrsD, oMrsD_nxt;
	logic [2*DW-1:0] oDq, oDq_nxt;
	logic [2*NL-1:0] oMsk, oMsk_nxt;
	logic [5:0] wl;
	logic pre2, bc4, canGo, badMode, start, active;
	logic [2:0] total;
	logic [7:0] tail;
	logic [127:0] allData;

	assign link.linkClk = clk_r;
	assign link.cmdWr = oWr;
	assign link.cmdAct = oAct;
	assign link.cmdMrs = oMrs;
	assign link.apBit = oAp;
	assign link.bsBit = oBs;
	assign link.bank = oBank;
	assign link.col = oCol;
	assign link.mrsData = oMrsD;
	assign link.dqsEn = oDqs;
	assign link.dq = oDq;
	assign link.maskInvN = oMsk;

	// Divider; link outputs change only as the link clock falls
	always_comb begin
		tick = clk_r && (div_r == 2'(LINK_HALF - 1));
		div_nxt = (div_r == 2'(LINK_HALF - 1)) ? 2'h0 : div_r + 2'h1;
		clk_nxt = (div_r == 2'(LINK_HALF - 1)) ? !clk_r : clk_r;
	end

	// Applied mode, issue checks
	always_comb begin
		wl = {1'b0, act_r[MF_AL +: MF_LATW]} + {1'b0, act_r[MF_CWL +: MF_LATW]};
		pre2 = act_r[MF_PRE2];
		bc4 = (act_r[MF_BM +: 2] == BM_BC4) || ((act_r[MF_BM +: 2] == BM_SEL) && !cmd_r[CF_BS]);
		tail = (act_r[MF_BM +: 2] == BM_BC4) ? TAIL_BC4 : TAIL_BL8;
		badMode = (mode_r[MF_PRE2] && (mode_r[MF_CWL +: MF_LATW] <= CWL_PRE2_BAD))
			|| (mode_r[MF_MASK] && mode_r[MF_DBI]);
		unique case (cmd_r[1:0])
			OP_WRITE: canGo = (since_r >= CCD_MIN) && !(pre2 && since_r == CCD_PRE2_BAD);
			OP_MODE: canGo = (wait_r == 8'h00); // Mode change only with the link idle
			default: canGo = 1'b1;
		endcase
	end

	// Registers, command issue and scheduling
	always_comb begin
		mode_nxt = mode_r;
		act_nxt = act_r;
		data_nxt = data_r;
		mask_nxt = mask_r;
		pend_nxt = pend_r;
		cmd_nxt = cmd_r;
		errCfg_nxt = errCfg_r;
		errBusy_nxt = errBusy_r;
		since_nxt = since_r;
		wait_nxt = wait_r;
		slot_nxt = slot_r;
		sData_nxt = sData_r;
		sMask_nxt = sMask_r;
		sch_nxt = sch_r;
		oWr_nxt = oWr;
		oAct_nxt = oAct;
		oMrs_nxt = oMrs;
		oAp_nxt = oAp;
		oBs_nxt = oBs;
		oBank_nxt = oBank;
		oCol_nxt = oCol;
		oMrsD_nxt = oMrsD;
		rdata_nxt = 32'h0000_0000;
		// Burst data words joined once, so a slot takes a plain slice of it
		allData = {data_r[3], data_r[2], data_r[1], data_r[0]};
		// Clears first so that a same-cycle set wins
		if (wrStb && addr == REG_STATUS) begin
			errCfg_nxt = errCfg_r && !wdata[1];
			errBusy_nxt = errBusy_r && !wdata[2];
		end
		if (wrStb) begin
			unique case (addr)
				REG_CMD: begin
					if (pend_r) begin
						errBusy_nxt = 1'b1;
					end else begin
						pend_nxt = 1'b1;
						cmd_nxt = wdata;
					end
				end
				REG_MODE: mode_nxt = wdata[15:0];
				REG_DATA0: data_nxt[0] = wdata;
				REG_DATA1: data_nxt[1] = wdata;
				REG_DATA2: data_nxt[2] = wdata;
				REG_DATA3: data_nxt[3] = wdata;
				REG_MASK: mask_nxt = wdata[15:0];
				default: ;
			endcase
		end
		if (rdStb) begin
			unique case (addr)
				REG_CMD: rdata_nxt = cmd_r;
				REG_MODE: rdata_nxt = {16'h0000, mode_r};
				REG_MASK: rdata_nxt = {16'h0000, mask_r};
				REG_STATUS: rdata_nxt = {28'h000_0000, wait_r == 8'h00, errBusy_r, errCfg_r, pend_r};
				REG_DATA0: rdata_nxt = data_r[0];
				REG_DATA1: rdata_nxt = data_r[1];
				REG_DATA2: rdata_nxt = data_r[2];
				REG_DATA3: rdata_nxt = data_r[3];
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		if (tick) begin
			oWr_nxt = 1'b0;
			oAct_nxt = 1'b0;
			oMrs_nxt = 1'b0;
			since_nxt = (since_r == SINCE_RST) ? since_r : since_r + 4'h1;
			wait_nxt = (wait_r == 8'h00) ? wait_r : wait_r - 8'h01;
			for (int i = 1; i < WLMAX; i++) begin
				sch_nxt[i] = sch_r[i-1];
			end
			sch_nxt[0] = '0;
			if (pend_r && canGo) begin
				pend_nxt = 1'b0;
				oAp_nxt = cmd_r[CF_AP];
				oBs_nxt = cmd_r[CF_BS];
				oBank_nxt = cmd_r[CF_BANK +: BANKW];
				oCol_nxt = cmd_r[CF_COL +: COLW];
				unique case (cmd_r[1:0])
					OP_WRITE: begin
						oWr_nxt = 1'b1;
						since_nxt = 4'h1;
						sch_nxt[0] = '{v: 1'b1, bc4: bc4, slot: slot_r};
						sData_nxt[slot_r] = allData[8*DW-1:0];
						sMask_nxt[slot_r] = mask_r[8*NL-1:0];
						slot_nxt = slot_r + 4'h1;
						// Precharge may follow after latency, tail and recovery
						wait_nxt = 8'(wl) + tail + TWR_CYC;
					end
					OP_ACT: oAct_nxt = 1'b1;
					OP_MODE: begin
						if (badMode) begin
							errCfg_nxt = 1'b1;
						end else begin
							oMrs_nxt = 1'b1;
							oMrsD_nxt = mode_r;
							act_nxt = mode_r;
						end
					end
					default: errCfg_nxt = 1'b1;
				endcase
			end
		end
	end

	// Data burst drive, preamble on the strobe enable
	always_comb begin
		tap = sch_r[wl - 6'h01];
		start = tap.v;
		curE = start ? tap : cur_r;
		curIdx = start ? 2'h0 : idx_r;
		total = curE.bc4 ? CYC_BC4 : CYC_BL8;
		active = start || (left_r != 3'h0);
		cur_nxt = cur_r;
		idx_nxt = idx_r;
		left_nxt = left_r;
		oDqs_nxt = oDqs;
		oDq_nxt = oDq;
		oMsk_nxt = oMsk;
		if (tick) begin
			cur_nxt = curE;
			idx_nxt = active ? curIdx + 2'h1 : 2'h0;
			left_nxt = start ? total - 3'h1 : ((left_r != 3'h0) ? left_r - 3'h1 : 3'h0);
			oDqs_nxt = active || sch_r[wl - 6'h02].v || (pre2 && sch_r[wl - 6'h03].v);
			oDq_nxt = sData_r[curE.slot][curIdx*2*DW +: 2*DW];
			oMsk_nxt = {(2*NL){1'b1}};
			if (act_r[MF_MASK] && active) begin
				oMsk_nxt = ~sMask_r[curE.slot][curIdx*2*NL +: 2*NL];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
			div_r <= 2'h0;
			clk_r <= 1'b0;
			mode_r <= MODE_RST;
			act_r <= MODE_RST;
			data_r <= '{default: 32'h0000_0000};
			mask_r <= 16'h0000;
			pend_r <= 1'b0;
			cmd_r <= 32'h0000_0000;
			errCfg_r <= 1'b0;
			errBusy_r <= 1'b0;
			since_r <= SINCE_RST;
			wait_r <= 8'h00;
			slot_r <= 4'h0;
			sData_r <= '{default: '0};
			sMask_r <= '{default: '0};
			sch_r <= '{default: '0};
			cur_r <= '0;
			left_r <= 3'h0;
			idx_r <= 2'h0;
			{oWr, oAct, oMrs, oAp, oBs, oDqs} <= 6'h00;
			oBank <= '0;
			oCol <= '0;
			oMrsD <= 16'h0000;
			oDq <= '0;
			oMsk <= '1;
		end else begin
			rdata <= rdata_nxt;
			div_r <= div_nxt;
			clk_r <= clk_nxt;
			mode_r <= mode_nxt;
			act_r <= act_nxt;
			data_r <= data_nxt;
			mask_r <= mask_nxt;
			pend_r <= pend_nxt;
			cmd_r <= cmd_nxt;
			errCfg_r <= errCfg_nxt;
			errBusy_r <= errBusy_nxt;
			since_r <= since_nxt;
			wait_r <= wait_nxt;
			slot_r <= slot_nxt;
			sData_r <= sData_nxt;
			sMask_r <= sMask_nxt;
			sch_r <= sch_nxt;
			cur_r <= cur_nxt;
			left_r <= left_nxt;
			idx_r <= idx_nxt;
			{oWr, oAct, oMrs, oAp, oBs, oDqs} <= {oWr_nxt, oAct_nxt, oMrs_nxt, oAp_nxt, oBs_nxt, oDqs_nxt};
			oBank <= oBank_nxt;
			oCol <= oCol_nxt;
			oMrsD <= oMrsD_nxt;
			oDq <= oDq_nxt;
			oMsk <= oMsk_nxt;
		end
	end
endmodule
`default_nettype wire

// ### dv/wbl_link_props.sv
// Link-side properties for the write-burst link between controller and device.
// Assumes it sees the interface wires plus the shared asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module wbl_link_props
	import wbl_pkg::*;
#(
	parameter int NL = 1
)(
	input wire logic linkClk,
	input wire logic rst,
	input wire logic cmdWr,
	input wire logic cmdMrs,
	input wire logic bsBit,
	input wire logic [15:0] mrsData,
	input wire logic dqsEn,
	input wire logic [2*NL-1:0] maskInvN
);
	default clocking cb @(posedge linkClk);
	endclocking
	default disable iff (rst);
	logic [15:0] mode_r, mode_nxt;
	logic [67:0] hist_r, hist_nxt, long_r, long_nxt;
	logic [6:0] wl;
	logic eight, ok, dataHit, preHit, lastHit;
	// Mode copy and write history; history runs past the deepest latency plus tail
	always_comb begin
		mode_nxt = cmdMrs ? mrsData : mode_r;
		eight = mode_r[1:0] != BM_BC4 && (mode_r[1:0] != BM_SEL || bsBit);
		hist_nxt = {hist_r[66:0], cmdWr};
		long_nxt = {long_r[66:0], cmdWr && eight};
		wl = 7'(mode_r[10:6]) + 7'(mode_r[15:11]);
		ok = wl >= 7'h03;
		dataHit = ok && hist_r[wl-7'h01];
		preHit = ok && (mode_r[MF_PRE2] ? hist_r[wl-7'h03] : hist_r[wl-7'h02]);
		lastHit = ok && long_r[wl+7'h02];
	end
	always_ff @(posedge linkClk or posedge rst) begin
		if (rst) begin
			mode_r <= MODE_RST;
			hist_r <= '0;
			long_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			hist_r <= hist_nxt;
			long_r <= long_nxt;
		end
	end
	wr_gap_a: assert property (cmdWr |=> !cmdWr [*3])
		else $error("writes closer than four link cycles");
	pre2_gap_a: assert property (cmdWr && mode_r[MF_PRE2] |-> !$past(cmdWr, 5))
		else $error("spacing of five with long preamble");
	mrs_mask_a: assert property (cmdMrs |-> !(mrsData[MF_MASK] && mrsData[MF_DBI]))
		else $error("mask sent with inversion");
	mrs_cwl_a: assert property (cmdMrs && mrsData[MF_PRE2] |-> mrsData[15:11] != CWL_PRE2_BAD)
		else $error("column latency nine with long preamble");
	data_lat_a: assert property (dataHit |-> dqsEn)
		else $error("no strobe at first data edge");
	pre_lat_a: assert property (preHit |-> dqsEn)
		else $error("no strobe in preamble");
	last_beat_a: assert property (lastHit |-> dqsEn)
		else $error("eight-beat burst cut short");
	idle_mask_a: assert property (!dqsEn |-> &maskInvN)
		else $error("mask pin low outside data");
	pin_idle_a: assert property (!mode_r[MF_MASK] && !mode_r[MF_DBI] |-> &maskInvN)
		else $error("pin driven with both functions off");
endmodule
`default_nettype wire

// ### dv/sdram_write_burst_logic_bench.sv
// Bench joining controller and device; drives the register port, checks stores.
// Assumes the controller makes the link clock from its own clock.
`timescale 1ns/100ps
`default_nettype none
module sdram_write_burst_logic_bench;
	import wbl_pkg::*;
	typedef struct packed {
		logic [15:0] d;
		logic [1:0] en;
		logic [9:0] c;
		logic [3:0] b;
		logic p;
	} wbl_exp_type;
	logic clock, rst, wrStb, rdStb, rdD, memWe, prechargeStart, crcOn, crcPersistent, strobeErr;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, v;
	logic [15:0] memData, bankOpen, m;
	logic [3:0] memBank, prechargeBank;
	logic [9:0] memCol;
	logic [1:0] memLaneEn;
	logic [63:0] re;
	logic mk;
	wbl_exp_type me;
	wbl_exp_type memQ[$];
	logic [63:0] rdQ[$];
	int errTotal = 0;
	int checksDone = 0;
	int cyc = 0;
	wbl_link_if wbl_link_if_i();
	wbl_mem_ctl wbl_mem_ctl_i(.clock(clock), .rst(rst),
		.addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
		.link(wbl_link_if_i));
	wbl_sdram_dev wbl_sdram_dev_i(.link(wbl_link_if_i),
		.rst(rst), .memWe(memWe), .memBank(memBank), .memCol(memCol), .memData(memData),
		.memLaneEn(memLaneEn), .prechargeStart(prechargeStart), .prechargeBank(prechargeBank),
		.bankOpen(bankOpen), .crcOn(crcOn), .crcPersistent(crcPersistent), .strobeErr(strobeErr));
	wbl_link_props wbl_link_props_i(.linkClk(wbl_link_if_i.linkClk), .rst(rst),
		.cmdWr(wbl_link_if_i.cmdWr), .cmdMrs(wbl_link_if_i.cmdMrs), .bsBit(wbl_link_if_i.bsBit),
		.mrsData(wbl_link_if_i.mrsData), .dqsEn(wbl_link_if_i.dqsEn),
		.maskInvN(wbl_link_if_i.maskInvN));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic chk(input logic good, input string msg);
		checksDone++;
		if (!good) begin
			errTotal++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Reads answer one cycle after the strobe; mask zero marks a poll
	always @(posedge clock) rdD <= rdStb;
	always @(negedge clock) begin
		if (rdD && rdQ.size() != 0) begin
			re = rdQ.pop_front();
			if (re[63:32] != 32'h0000_0000) chk((rdata & re[63:32]) === re[31:0], "register read");
		end
	end
	// Every stored data cycle is matched against the oldest note
	always @(negedge wbl_link_if_i.linkClk) begin
		if (memWe === 1'b1) begin
			if (memQ.size() == 0) chk(1'b0, "unexpected store");
			else begin
				me = memQ.pop_front();
				chk({memData, memLaneEn, memCol, memBank, prechargeStart} === me, "store");
				if (prechargeStart === 1'b1) chk(prechargeBank === me.b, "precharge bank");
			end
		end
		if (strobeErr === 1'b1) chk(1'b0, "strobe missing in data");
	end
	// Hang guard, far above the expected run length
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errTotal++;
			results();
		end
	end
	task automatic op(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wrStb <= 1'b1;
		@(posedge clock);
		wrStb <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [63:0] e, output logic [31:0] q);
		rdQ.push_back(e);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clock);
		rdStb <= 1'b0;
		#1 q = rdata;
		@(posedge clock);
	endtask
	// Bounded poll of the pending flag
	task automatic waitIdle();
		logic [31:0] q;
		q = 32'h0000_0001;
		for (int i = 0; i < 400 && q[0] !== 1'b0; i++) rd(REG_STATUS, 64'h0, q);
		// A command stuck in pending is a hang, not a pass
		if (q[0] !== 1'b0) chk(1'b0, "command never issued");
	endtask
	task automatic setMode(input logic [15:0] w);
		op(REG_MODE, {16'h0000, w});
		op(REG_CMD, {30'h0000_0000, OP_MODE});
		waitIdle();
		repeat (12) @(posedge clock);
	endtask
	task automatic act(input logic [3:0] b);
		op(REG_CMD, 32'(b) << CF_BANK | 32'(OP_ACT));
		waitIdle();
	endtask
	// One burst: notes go in before the command; twice strobes the command two cycles
	task automatic burst(input logic [15:0] w, input logic bs, input logic ap,
		input logic [3:0] b, input logic twice, input logic drain);
		logic [63:0] d;
		logic [7:0] mask;
		logic [9:0] c;
		int n;
		d = {$urandom, $urandom};
		mask = 8'($urandom);
		c = 10'($urandom) & 10'h3f8;
		n = (w[1:0] == BM_BC4 || (w[1:0] == BM_SEL && !bs)) ? 2 : 4;
		op(REG_DATA0, d[31:0]);
		op(REG_DATA1, d[63:32]);
		op(REG_MASK, {24'h00_0000, mask});
		for (int k = 0; k < n; k++) begin
			memQ.push_back({d[16*k +: 16], w[MF_MASK] ? ~mask[2*k +: 2] : 2'h3, c + 10'(2*k), b,
				ap && k == n - 1});
		end
		addr <= REG_CMD;
		wdata <= 32'(c) << CF_COL | 32'(b) << CF_BANK | 32'(bs) << CF_BS | 32'(ap) << CF_AP;
		wrStb <= 1'b1;
		repeat (twice ? 2 : 1) @(posedge clock);
		wrStb <= 1'b0;
		@(posedge clock);
		waitIdle();
		if (drain) begin
			for (int i = 0; i < 400 && memQ.size() != 0; i++) @(posedge clock);
			repeat (8) @(posedge clock);
			chk(memQ.size() == 0, "burst not stored");
			chk(bankOpen[b] === !ap, "bank state after burst");
		end
	endtask
	initial begin
		rst = 1'b1;
		wrStb = 1'b0;
		rdStb = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		void'($urandom(32'h0000_46fd));
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		// Reset values, a read-write data register and an unmapped hole
		rd(REG_MODE, {32'hffff_ffff, 16'h0000, MODE_RST}, v);
		rd(REG_STATUS, 64'h0000_0007_0000_0000, v);
		op(REG_DATA2, 32'ha5c3_0f1e);
		rd(REG_DATA2, 64'hffff_ffff_a5c3_0f1e, v);
		rd(8'h20, 64'hffff_ffff_0000_0000, v);
		$display("test reset done");
		// Mask with inversion, long preamble with latency nine, illegal op
		for (int i = 0; i < 3; i++) begin
			if (i < 2) op(REG_MODE, i == 0 ? 32'h0000_500c : 32'h0000_4820);
			op(REG_CMD, i < 2 ? 32'h0000_0002 : 32'h0000_0003);
			waitIdle();
			rd(REG_STATUS, 64'h0000_0002_0000_0002, v);
			op(REG_STATUS, 32'h0000_0002);
			rd(REG_STATUS, 64'h0000_0002_0000_0000, v);
		end
		$display("test refusals done");
		// Every burst code, both select values, random latency and features
		for (int i = 0; i < 8; i++) begin
			mk = 1'($urandom);
			m = {5'h0a, 5'($urandom % 4), 1'($urandom), 1'($urandom), !mk && 1'($urandom), mk, 2'(i / 2)};
			setMode(m);
			chk(crcOn === m[MF_CRC], "crc enable");
			if (m[MF_CRC]) chk(crcPersistent === m[MF_MASK], "crc persistence");
			act(4'(i));
			burst(m, i[0], 1'($urandom), 4'(i), 1'b0, 1'b1);
			// Recovery still runs just after the data, and has run out well later
			rd(REG_STATUS, 64'h0000_0008_0000_0000, v);
			repeat (80) @(posedge clock);
			rd(REG_STATUS, 64'h0000_0008_0000_0008, v);
		end
		$display("test burst modes done");
		// Back to back and late second writes, short and long preamble, then a doubled strobe
		for (int j = 0; j < 4; j++) begin
			m = j[0] ? 16'h5020 : 16'h5000;
			setMode(m);
			act(4'h1);
			act(4'h2);
			burst(m, 1'b1, 1'b0, 4'h1, 1'b0, 1'b0);
			// Late request lands on spacing five; long preamble must push it to six
			if (j > 1) repeat (9) @(posedge clock);
			burst(m, 1'b1, 1'b1, 4'h2, 1'b0, 1'b1);
		end
		act(4'h3);
		burst(m, 1'b0, 1'b0, 4'h3, 1'b1, 1'b1);
		rd(REG_STATUS, 64'h0000_0004_0000_0004, v);
		$display("test back to back done");
		results();
	end
endmodule
`default_nettype wire
